/* File: ubg_baud_gen.sv */
// prescaler, fractional divider, normal divider and count-down baud timer
`timescale 1ns/1ps
module ubg_baud_gen (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // configuration
    input wire ubg_pkg::ubg_baud_cfg_type cfg_in,
    input wire logic divider_flag_clear_in,
    // results
    output logic baud_tick_out,
    output logic divider_overflow_flag_out,
    output logic divider_irq_out
);

    logic [ubg_pkg::PRESCALE_CNT_W-1:0] pre_cnt;
    logic [7:0] frac_acc;
    logic [7:0] ndiv_cnt;
    logic [7:0] timer_cnt;

    ////////////////////////////////////////////////////////////////////////////
    wire [7:0] pre_shift = 8'h01 << cfg_in.prescale_exponent;
    wire [ubg_pkg::PRESCALE_CNT_W-1:0] pre_mask = pre_shift[6:0] - 7'h01;
    wire div_tick = (pre_cnt & pre_mask) == pre_mask;
    wire frac_on = cfg_in.divider_enable_bit && !cfg_in.divider_mode_select;
    wire ndiv_on = cfg_in.divider_enable_bit && cfg_in.divider_mode_select;
    wire [8:0] frac_sum = {1'b0, frac_acc} + {1'b0, cfg_in.fraction_register};
    wire mod_tick = div_tick && frac_sum[8];
    wire timer_tick = cfg_in.divider_enable_bit ? mod_tick : div_tick;
    // normal divider mode stalls the baud timer whatever the run bit says
    wire timer_run = cfg_in.baud_timer_run && !ndiv_on;
    wire underflow = timer_run && timer_tick && (timer_cnt == 8'h00);
    wire ndiv_ovf = ndiv_on && div_tick && (ndiv_cnt == 8'hFF);
    wire [7:0] next_timer = underflow ? cfg_in.baud_reload_value : timer_cnt - 8'h01;
    wire [7:0] next_ndiv = ndiv_ovf ? cfg_in.fraction_register : ndiv_cnt + 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pre_cnt <= '0;
            frac_acc <= ubg_pkg::DIVIDER_RESET;
            ndiv_cnt <= ubg_pkg::DIVIDER_RESET;
            timer_cnt <= ubg_pkg::TIMER_RESET;
            baud_tick_out <= 1'b0;
            divider_overflow_flag_out <= 1'b0;
            divider_irq_out <= 1'b0;
        end else begin
            pre_cnt <= div_tick ? '0 : pre_cnt + 7'h01;
            if (frac_on && div_tick) begin
                frac_acc <= frac_sum[7:0];
            end
            if (ndiv_on && div_tick) begin
                ndiv_cnt <= next_ndiv;
            end
            if (timer_run && timer_tick) begin
                timer_cnt <= next_timer;
            end
            baud_tick_out <= underflow;
            divider_irq_out <= ndiv_ovf;
            // a new overflow beats a clear in the same cycle
            if (ndiv_ovf) begin
                divider_overflow_flag_out <= 1'b1;
            end else if (divider_flag_clear_in) begin
                divider_overflow_flag_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_run_gates_timer: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        !timer_run |=> !baud_tick_out)
        else $error("baud pulse while timer stopped");
    a_underflow_reload: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        baud_tick_out |-> timer_cnt == $past(cfg_in.baud_reload_value))
        else $error("timer not reloaded on underflow");
    a_ndiv_flag_set: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        divider_irq_out |-> divider_overflow_flag_out)
        else $error("overflow request without flag");
    c_ndiv_overflow: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) divider_irq_out);

endmodule : ubg_baud_gen

/* File: ubg_pkg.sv */
// shared constants and carrier types for the serial port and its bit-rate generator
package ubg_pkg;

    // operating modes
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
    localparam logic [1:0] MODE_UART9_VAR = 2'h3;

    // prescaler: divide by two to the power of a 3-bit exponent
    localparam int PRESCALE_EXP_W = 3;
    localparam int PRESCALE_CNT_W = 7;

    // oversampling of each bit
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_POINT = 4'h7;

    // bits per frame, start and stop included in the async frames
    localparam logic [3:0] FRAME8_BITS = 4'hA;
    localparam logic [3:0] FRAME9_BITS = 4'hB;
    localparam logic [3:0] SHIFT0_BITS = 4'h8;

    // fixed mode-2 sample rates: clock / 2 or clock / 4, i.e. bit = clock / 32 or / 64
    localparam logic [1:0] FIX_FAST_MASK = 2'h1;
    localparam logic [1:0] FIX_SLOW_MASK = 2'h3;

    // reset values
    localparam logic [7:0] TIMER_RESET = 8'h00;
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [8:0] RX_WORD_RESET = 9'h000;
    localparam logic [10:0] TX_IDLE_LINE = 11'h7FF;

    // bit-rate generator configuration
    typedef struct packed {
        logic baud_timer_run;
        logic divider_enable_bit;
        logic divider_mode_select;
        logic [2:0] prescale_exponent;
        logic [7:0] baud_reload_value;
        logic [7:0] fraction_register;
    } ubg_baud_cfg_type;

    // serial port configuration
    typedef struct packed {
        logic [1:0] mode;
        logic double_rate_bit;
        logic use_timer_one;
    } ubg_port_cfg_type;

endpackage : ubg_pkg

/* File: ubg_remote.sv */
// behavioural remote serial node facing the port's line
`timescale 1ns/1ps
module ubg_remote (
    // clock
    input wire logic sys_clk_in,
    // serial line
    input wire logic txd_in,
    output logic rxd_out
);
    ////////////////////////////////////////////////////////////////
    // line idles high between frames
    initial rxd_out = 1'b1;

    // frame holds start, data lsb first, stop; nb bits of per clocks each
    task automatic send(input logic [10:0] frame, input int nb, input int per);
        for (int i = 0; i < nb; i++) begin
            @(negedge sys_clk_in);
            rxd_out = frame[i];
            repeat (per - 1) @(negedge sys_clk_in);
        end
        rxd_out = 1'b1;
    endtask : send

    // samples mid-bit after the falling start edge, start bit kept in bit 0;
    // returns inside the stop bit so the caller still sees the done pulse
    task automatic collect(input int nb, input int per, output logic [10:0] got);
        got = 11'h000;
        @(negedge txd_in);
        for (int i = 0; i < nb; i++) begin
            repeat ((i == 0) ? per / 2 : per) @(negedge sys_clk_in);
            got[i] = txd_in;
        end
    endtask : collect
endmodule : ubg_remote

/* File: ubg_uart.sv */
// serial port with shift-register mode, 8/9-bit async frames and one-deep receive buffer
//
// Behaviour
// - a new byte may arrive while one is unread; on collision one is dropped
// - frames carry 8 or 9 data bits, least significant bit first
// - mode 0 is an 8-bit shift register clocked at clock / 2
// - mode 1 is 8-bit variable; modes 2 and 3 are 9-bit fixed and variable
// - mode 2 bit rate is clock/32 or clock/64; second port only clock/64
// - variable rate from baud timer underflow, or Timer 1 on the first port
// - baud timer counts down, fed by fractional divider or by prescaler
// - bit rates need fractional mode or the divider off; run acts in both
// - each underflow reloads the timer and gives one pulse to the channel
// - normal divider mode stops the baud timer and ignores run
// - prescaler divides by two to the power of a 3-bit exponent
// - fractional divider scales by step over 256, only in fractional mode
// - rate is clock / 16 / prescale / (reload + 1); product must exceed 1
// - a pulse marks every completed transmission and every completed reception
// - Timer 1 rate is 2^double times clock / (64 times (256 - high byte))
// - normal divider mode: 8-bit up counter reloading from step, flag and request
`timescale 1ns/1ps
module ubg_uart #(
    parameter bit IS_SECOND_PORT = 1'b0
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // configuration
    input wire ubg_pkg::ubg_port_cfg_type port_cfg_in,
    input wire ubg_pkg::ubg_baud_cfg_type baud_cfg_in,
    input wire logic divider_flag_clear_in,
    input wire logic timer_one_overflow_in,
    // transmit request
    input wire logic tx_start_in,
    input wire logic [8:0] tx_data_in,
    // receive buffer
    input wire logic rx_read_in,
    // serial line
    input wire logic rxd_in,
    output logic txd_out,
    output logic shift_clk_out,
    // status and events
    output logic tx_busy_out,
    output logic tx_done_out,
    output logic [8:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_done_out,
    output logic rx_lost_out,
    output logic divider_overflow_flag_out,
    output logic divider_irq_out
);

    typedef enum logic {TX_IDLE, TX_SHIFT} ubg_tx_state_type;
    typedef enum logic {RX_IDLE, RX_BITS} ubg_rx_state_type;

    ubg_tx_state_type tx_state;
    ubg_rx_state_type rx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_left;
    logic [3:0] tx_sub;
    logic [3:0] rx_sub;
    logic [3:0] rx_count;
    logic [8:0] rx_shift;
    logic rxd_prev;
    logic t1_half;
    logic [1:0] fix_cnt;
    logic baud_tick;

    ////////////////////////////////////////////////////////////////////////////
    ubg_baud_gen u_baud_gen (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .cfg_in(baud_cfg_in),
        .divider_flag_clear_in(divider_flag_clear_in),
        .baud_tick_out(baud_tick),
        .divider_overflow_flag_out(divider_overflow_flag_out),
        .divider_irq_out(divider_irq_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sample tick: sixteen per bit in the async modes
    wire mode0 = port_cfg_in.mode == ubg_pkg::MODE_SHIFT;
    wire mode1 = port_cfg_in.mode == ubg_pkg::MODE_UART8;
    wire mode2 = port_cfg_in.mode == ubg_pkg::MODE_UART9_FIXED;
    // one timer 1 overflow per sample tick when doubled, every second one otherwise
    wire t1_tick = timer_one_overflow_in && (port_cfg_in.double_rate_bit || t1_half);
    wire use_t1 = port_cfg_in.use_timer_one && !IS_SECOND_PORT;
    wire var_tick = use_t1 ? t1_tick : baud_tick;
    wire fix_fast = port_cfg_in.double_rate_bit && !IS_SECOND_PORT;
    wire [1:0] fix_mask = fix_fast ? ubg_pkg::FIX_FAST_MASK : ubg_pkg::FIX_SLOW_MASK;
    wire fix_tick = (fix_cnt & fix_mask) == fix_mask;
    wire sample_tick = mode2 ? fix_tick : var_tick;
    wire [3:0] frame_bits = mode1 ? ubg_pkg::FRAME8_BITS : ubg_pkg::FRAME9_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // transmit; in mode 0 the shift clock is low then high for each bit
    wire tx_accept = tx_start_in && tx_state == TX_IDLE;
    wire [10:0] tx_frame = mode0 ? {3'h7, tx_data_in[7:0]} :
        mode1 ? {2'h3, tx_data_in[7:0], 1'b0} : {1'b1, tx_data_in, 1'b0};
    wire [3:0] tx_bits = mode0 ? ubg_pkg::SHIFT0_BITS : frame_bits;
    wire tx_bit_end = tx_state == TX_SHIFT &&
        (mode0 ? shift_clk_out : (sample_tick && tx_sub == ubg_pkg::SUB_LAST));
    wire tx_last = tx_bit_end && tx_left == 4'h1;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_state <= TX_IDLE;
            tx_shift <= ubg_pkg::TX_IDLE_LINE;
            tx_left <= 4'h0;
            tx_sub <= 4'h0;
            shift_clk_out <= 1'b1;
            tx_done_out <= 1'b0;
        end else begin
            tx_done_out <= tx_last;
            if (tx_accept) begin
                tx_state <= TX_SHIFT;
                tx_shift <= tx_frame;
                tx_left <= tx_bits;
                tx_sub <= 4'h0;
                shift_clk_out <= !mode0;
            end else if (tx_state == TX_SHIFT) begin
                // the shift clock rests high once the last bit has gone out
                if (mode0) begin
                    shift_clk_out <= !shift_clk_out || tx_last;
                end
                if (sample_tick) begin
                    tx_sub <= tx_sub + 4'h1;
                end
                if (tx_bit_end) begin
                    tx_shift <= {1'b1, tx_shift[10:1]};
                    tx_left <= tx_left - 4'h1;
                end
                if (tx_last) begin
                    tx_state <= TX_IDLE;
                end
            end
        end
    end

    assign txd_out = tx_shift[0];
    assign tx_busy_out = tx_state == TX_SHIFT;

    ////////////////////////////////////////////////////////////////////////////
    // receive: mode 0 samples at the end of each high shift-clock phase, async at mid-bit
    wire rx_fall = rxd_prev && !rxd_in && !mode0;
    wire rx_mid = rx_state == RX_BITS && sample_tick && rx_sub == ubg_pkg::SAMPLE_POINT;
    wire rx_false_start = rx_mid && rx_count == 4'h0 && rxd_in;
    wire rx_stop = rx_mid && rx_count == frame_bits - 4'h1;
    wire rx_data_bit = rx_mid && rx_count != 4'h0 && !rx_stop;
    wire rx0_bit = mode0 && tx_bit_end;
    wire [8:0] next_rx_shift = {rxd_in, rx_shift[8:1]};
    wire [8:0] rx_word = mode0 ? {1'b0, rxd_in, rx_shift[8:2]} :
        mode1 ? {rxd_in, rx_shift[8:1]} : rx_shift;
    wire rx_new = (mode0 && tx_last) || rx_stop;
    // second byte is dropped while the first still waits to be read
    wire rx_collide = rx_new && rx_valid_out && !rx_read_in;

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_state <= RX_IDLE;
            rx_sub <= 4'h0;
            rx_count <= 4'h0;
            rx_shift <= ubg_pkg::RX_WORD_RESET;
            rxd_prev <= 1'b1;
        end else begin
            rxd_prev <= rxd_in;
            if (rx0_bit || rx_data_bit) begin
                rx_shift <= next_rx_shift;
            end
            if (rx_state == RX_IDLE) begin
                if (rx_fall) begin
                    rx_state <= RX_BITS;
                    rx_sub <= 4'h0;
                    rx_count <= 4'h0;
                end
            end else begin
                if (sample_tick) begin
                    rx_sub <= rx_sub + 4'h1;
                end
                if (rx_mid) begin
                    rx_count <= rx_count + 4'h1;
                end
                if (rx_false_start || rx_stop || mode0) begin
                    rx_state <= RX_IDLE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_data_out <= ubg_pkg::RX_WORD_RESET;
            rx_valid_out <= 1'b0;
            rx_done_out <= 1'b0;
            rx_lost_out <= 1'b0;
        end else begin
            rx_done_out <= rx_new;
            rx_lost_out <= rx_collide;
            if (rx_new && !rx_collide) begin
                rx_data_out <= rx_word;
                rx_valid_out <= 1'b1;
            end else if (rx_read_in) begin
                rx_valid_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            t1_half <= 1'b0;
            fix_cnt <= 2'h0;
        end else begin
            fix_cnt <= fix_cnt + 2'h1;
            if (timer_one_overflow_in) begin
                t1_half <= !t1_half;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_mode0_clock_rate: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (tx_busy_out && mode0 && !shift_clk_out) |=> shift_clk_out)
        else $error("shift clock low longer than one cycle");
    a_mode0_length: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (tx_accept && mode0) |-> ##17 tx_done_out)
        else $error("mode 0 transfer not 16 cycles");
    a_start_bit_low: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        (tx_accept && !mode0) |=> !txd_out)
        else $error("frame does not open with low bit");
    a_tx_done_idle: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        tx_done_out |-> !tx_busy_out && txd_out)
        else $error("done while still shifting");
    a_lost_keeps_old: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        rx_lost_out |-> $stable(rx_data_out) && rx_valid_out)
        else $error("unread byte overwritten");
    a_rx_done_valid: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        rx_done_out |-> rx_valid_out)
        else $error("reception done without buffered byte");
    c_rx_lost: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) rx_lost_out);
    c_rx_mode3: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
        rx_done_out && port_cfg_in.mode == ubg_pkg::MODE_UART9_VAR);
    c_tx_mode1: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) tx_done_out && mode1);

endmodule : ubg_uart

/* File: ubg_uart_test.sv */
// self-checking testbench for the serial port and its bit-rate generator
`timescale 1ns/1ps
module ubg_uart_test;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    ubg_pkg::ubg_port_cfg_type port_cfg = '0;
    ubg_pkg::ubg_baud_cfg_type baud_cfg = '0;
    logic flag_clear = 1'b0;
    logic t1_ovf = 1'b0;
    logic t1_on = 1'b0;
    logic tx_start = 1'b0;
    logic [8:0] tx_data = 9'h000;
    logic rx_read = 1'b0;
    logic rxd;
    logic txd;
    logic shift_clk;
    logic tx_busy;
    logic tx_done;
    logic [8:0] rx_data;
    logic rx_valid;
    logic rx_done;
    logic rx_lost;
    logic div_flag;
    logic div_irq;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;
    int t0 = 0;
    int irq_cnt = 0;
    int lost_cnt = 0;
    int done_cnt = 0;

    ubg_uart ubg_uart_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .port_cfg_in(port_cfg),
        .baud_cfg_in(baud_cfg), .divider_flag_clear_in(flag_clear), .timer_one_overflow_in(t1_ovf),
        .tx_start_in(tx_start), .tx_data_in(tx_data), .rx_read_in(rx_read), .rxd_in(rxd), .txd_out(txd),
        .shift_clk_out(shift_clk), .tx_busy_out(tx_busy), .tx_done_out(tx_done), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_done_out(rx_done), .rx_lost_out(rx_lost),
        .divider_overflow_flag_out(div_flag), .divider_irq_out(div_irq));
    ubg_remote ubg_remote_inst (.sys_clk_in(sys_clk_in), .txd_in(txd), .rxd_out(rxd));

    ////////////////////////////////////////////////////////////////
    always #12.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) cyc <= cyc + 1;
    // event pulses last one cycle, so one look per cycle counts each once
    always @(negedge sys_clk_in) begin
        irq_cnt += int'(div_irq === 1'b1);
        lost_cnt += int'(rx_lost === 1'b1);
        done_cnt += int'(rx_done === 1'b1);
    end
    // timer one stand-in: one overflow every 4 clocks
    always begin
        @(negedge sys_clk_in);
        if (t1_on) begin
            repeat (2) @(negedge sys_clk_in);
            t1_ovf = 1'b1;
            @(negedge sys_clk_in);
            t1_ovf = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic conclude;
        $display("errors=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    function automatic logic [10:0] frm(input logic [8:0] d, input int nb);
        return (nb == 10) ? {2'h1, d[7:0], 1'h0} : {1'h1, d, 1'h0};
    endfunction : frm

    task automatic pulse(ref logic s);
        @(negedge sys_clk_in);
        s = 1'b1;
        @(negedge sys_clk_in);
        s = 1'b0;
    endtask : pulse

    task automatic pulse_start(input logic [8:0] d);
        tx_data = d;
        pulse(tx_start);
        t0 = cyc;
    endtask : pulse_start

    // bounded wait; n is cycles since the accepting edge
    task automatic wait_done(output int n);
        int k;
        k = 0;
        while (tx_done !== 1'b1 && k < 3000) begin
            @(negedge sys_clk_in);
            k++;
        end
        n = cyc - t0;
        cmp(11'(tx_done), 11'h001);
    endtask : wait_done

    task automatic tx_async(input logic [8:0] d, input int nb, input int per);
        logic [10:0] got;
        int n;
        fork
            ubg_remote_inst.collect(nb, per, got);
            pulse_start(d);
        join
        wait_done(n);
        cmp(got, frm(d, nb));
    endtask : tx_async

    ////////////////////////////////////////////////////////////////
    task automatic mode_zero;
        logic [7:0] got;
        int n;
        fork
            for (int i = 0; i < 8; i++) begin
                @(posedge shift_clk);
                got[i] = txd;
            end
            pulse_start(9'h0C5);
            // full duplex: one input bit per two clocks, first slot unused
            ubg_remote_inst.send(frm(9'h03A, 10), 9, 2);
        join
        wait_done(n);
        // eight bits of two clocks each
        cmp(11'(n), 11'd16);
        cmp(11'(got), 11'h0C5);
        cmp(11'(rx_data), 11'h03A);
        cmp(11'(shift_clk), 11'h001);
        pulse(rx_read);
    endtask : mode_zero

    task automatic rx_overrun;
        lost_cnt = 0;
        done_cnt = 0;
        port_cfg = '{mode: ubg_pkg::MODE_UART9_FIXED, double_rate_bit: 1'b1, use_timer_one: 1'b0};
        ubg_remote_inst.send(frm(9'h1A5, 11), 11, 32);
        cmp({rx_valid, rx_data, 1'b0}, {1'b1, 9'h1A5, 1'b0});
        ubg_remote_inst.send(frm(9'h03C, 11), 11, 32);
        cmp({rx_valid, rx_data, 1'b0}, {1'b1, 9'h1A5, 1'b0});
        cmp(11'(lost_cnt), 11'd1);
        cmp(11'(done_cnt), 11'd2);
        pulse(rx_read);
        cmp(11'(rx_valid), 11'h000);
        port_cfg.double_rate_bit = 1'b0;
        tx_async(9'h0F3, 11, 64);
    endtask : rx_overrun

    task automatic run_and_divider;
        int n;
        port_cfg = '{mode: ubg_pkg::MODE_UART8, double_rate_bit: 1'b0, use_timer_one: 1'b0};
        baud_cfg = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h01, 8'hFC};
        pulse_start(9'h055);
        n = 0;
        while (div_irq !== 1'b1 && n < 600) begin
            @(negedge sys_clk_in);
            n++;
        end
        // clear and read the counter away from the falling edge where it counts
        @(posedge sys_clk_in);
        irq_cnt = 0;
        repeat (40) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
        cmp(11'(irq_cnt), 11'd10);
        @(negedge sys_clk_in);
        cmp({div_flag, tx_busy}, 11'h003);
        baud_cfg = '{1'b0, 1'b0, 1'b0, 3'h0, 8'h01, 8'hFC};
        repeat (400) @(negedge sys_clk_in);
        cmp(11'(tx_busy), 11'h001);
        baud_cfg.baud_timer_run = 1'b1;
        wait_done(n);
        pulse(flag_clear);
        cmp(11'(div_flag), 11'h000);
    endtask : run_and_divider

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        cmp({txd, shift_clk, tx_busy, rx_valid}, 11'h00C);
        mode_zero();
        rx_overrun();
        // exponent codes 000, 001, 010 with reload 1: bit = 32 << code clocks
        port_cfg = '{mode: ubg_pkg::MODE_UART8, double_rate_bit: 1'b0, use_timer_one: 1'b0};
        for (int e = 0; e < 3; e++) begin
            baud_cfg = '{1'b1, 1'b0, 1'b0, 3'(e), 8'h01, 8'h00};
            tx_async(9'h05A, 10, 32 << e);
        end
        // step 0x80 halves the timer clock: bit = 64 clocks
        port_cfg.mode = ubg_pkg::MODE_UART9_VAR;
        baud_cfg = '{1'b1, 1'b1, 1'b0, 3'h0, 8'h01, 8'h80};
        tx_async(9'h133, 11, 64);
        port_cfg = '{mode: ubg_pkg::MODE_UART8, double_rate_bit: 1'b1, use_timer_one: 1'b1};
        t1_on = 1'b1;
        tx_async(9'h0A7, 10, 64);
        port_cfg.double_rate_bit = 1'b0;
        tx_async(9'h0A7, 10, 128);
        t1_on = 1'b0;
        run_and_divider();
        conclude();
    end

    initial begin
        repeat (40000) @(posedge sys_clk_in);
        err_total++;
        conclude();
    end
endmodule : ubg_uart_test
